// ===== src/spr_protect.sv
`timescale 1ns/1ps

// Summary of operation
// (R1) Internal reset is asserted by either the power-on reset or the external active-low system reset.
// (R2) With enable high the drive follows the phase command; with enable low all four drive outputs are off.
// (R3) With enable low the internal clock is frozen and all inputs except the system reset are ignored.
// (R4) The open-drain any-fault flag is pulled low whenever an open, overcurrent or overheat fault is latched.
// (R5) The fault-type output reports open terminal, overcurrent or overheat as one of three levels.
// (R6) Every detected fault is latched and holds the drive outputs off until a reset.
// (R7) A latched fault is cleared only by the external system reset or a power-on reset.
// (R8) The controller restores drive after a fault by a power-on reset or a high-low-high reset pulse.
// (R9) The controller keeps enable low while the logic supply is below 4.75V.
// (R10) The controller waits at least 10us after reset release before any step clock edge.
// (R11) The controller ramps the step clock period up to stop rather than halting abruptly.
// (R12) An open terminal is found by the absence of flyback current in the PWM off part and is latched.
// (R13) The controller avoids PWM chopping within 30us after enable rises to avoid false open detection.
// (R14) Current sensing is blanked for the first 5.5us of each PWM period during PWM operation.
// (R15) Blanking is aligned to PWM periods only and does not cover the initial current rise.
// (R16) Overcurrent is flagged only after the blanking interval of a PWM period and turns all drive off.
// (R17) Clearing the fault latch releases the any-fault flag and the fault-type output together.
module spr_protect (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic i_system_reset_low,
	input wire logic [spr_pkg::DRIVE_W-1:0] i_phase_cmd,
	input wire logic i_chop_active,
	input wire logic i_pwm_period_start,
	input wire logic i_pwm_off,
	input wire logic i_over_current_cmp,
	input wire logic i_over_heat,
	input wire logic i_flyback_seen,
	output logic [spr_pkg::DRIVE_W-1:0] o_drive,
	output logic o_sense_blank,
	output logic o_any_fault_flag_low_o,
	output logic o_any_fault_flag_low_oe,
	output logic [1:0] o_fault_type_level
);

	// Pin levels brought into the clock domain
	logic [spr_pkg::SYNC_W-1:0] pins_async;
	logic [spr_pkg::SYNC_W-1:0] pins_s;

	assign pins_async[spr_pkg::SYNC_ENABLE] = i_enable;
	assign pins_async[spr_pkg::SYNC_RESET_LOW] = i_system_reset_low;
	assign pins_async[spr_pkg::SYNC_OVER_CURRENT] = i_over_current_cmp;
	assign pins_async[spr_pkg::SYNC_OVER_HEAT] = i_over_heat;
	assign pins_async[spr_pkg::SYNC_FLYBACK] = i_flyback_seen;

	spr_sync #(
		.WIDTH(spr_pkg::SYNC_W),
		.RESET_VAL(spr_pkg::SYNC_RESET_VAL)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_async(pins_async),
		.o_sync(pins_s)
	);

	wire en_s = pins_s[spr_pkg::SYNC_ENABLE];
	wire ext_rst_low_s = pins_s[spr_pkg::SYNC_RESET_LOW];
	wire over_current_s = pins_s[spr_pkg::SYNC_OVER_CURRENT];
	wire over_heat_s = pins_s[spr_pkg::SYNC_OVER_HEAT];
	wire flyback_s = pins_s[spr_pkg::SYNC_FLYBACK];

	// The external reset acts synchronously; power-on reset is the async path
	wire soft_rst = !ext_rst_low_s; // R1
	// Internal clock enable: everything but reset freezes while disabled
	wire ce = en_s && !soft_rst; // R3

	// State
	spr_pkg::spr_fault_t fault_q;
	spr_pkg::spr_fault_t fault_d;
	logic [spr_pkg::BLANK_W-1:0] blank_cnt_q;
	logic [spr_pkg::BLANK_W-1:0] blank_cnt_d;
	logic pwm_off_q;
	logic flyback_hit_q;
	logic flyback_hit_d;
	logic [spr_pkg::DRIVE_W-1:0] drive_q;
	logic blank_q;
	logic flag_oe_q;

	// Blanking window restarts on each PWM period, never on the initial rise
	wire blank_start = ce && i_chop_active && i_pwm_period_start; // R14 R15
	wire blank_busy = blank_cnt_q != spr_pkg::BLANK_ZERO;
	assign blank_cnt_d = blank_start ? spr_pkg::BLANK_LOAD :
		(ce && blank_busy) ? blank_cnt_q - spr_pkg::BLANK_STEP : blank_cnt_q; // R14

	// Overcurrent only counts inside a PWM period once blanking has run out
	wire oc_event = ce && i_chop_active && !blank_busy && !blank_start && over_current_s; // R16

	// Open terminal: an off part that ends with no flyback current seen
	wire off_end = ce && i_chop_active && pwm_off_q && !i_pwm_off; // R12
	wire open_event = off_end && !(flyback_hit_q || flyback_s); // R12
	assign flyback_hit_d = (ce && off_end) ? 1'b0 :
		(ce && i_chop_active && i_pwm_off) ? (flyback_hit_q || flyback_s) : flyback_hit_q;

	// Overheat needs no blanking: it is a slow substrate level, not a current edge
	wire heat_event = ce && over_heat_s; // R4

	// First fault wins and is held; heat outranks overcurrent outranks open
	wire no_fault = fault_q == spr_pkg::SPR_FAULT_NONE;
	always_comb begin
		fault_d = fault_q;
		if (no_fault) begin
			case (1'b1)
				heat_event: fault_d = spr_pkg::SPR_FAULT_OVER_HEAT; // R5
				oc_event: fault_d = spr_pkg::SPR_FAULT_OVER_CURRENT; // R5 R16
				open_event: fault_d = spr_pkg::SPR_FAULT_OPEN; // R5 R12
				default: fault_d = fault_q;
			endcase
		end
	end
	wire fault_next_any = fault_d != spr_pkg::SPR_FAULT_NONE;

	// One gate per excitation output; a shared permit cuts all four on the same edge
	wire drive_permit = en_s && !soft_rst && !fault_next_any; // R2 R6
	logic [spr_pkg::DRIVE_W-1:0] drive_d;
	for (genvar g = 0; g < spr_pkg::DRIVE_W; g++) begin : g_drive
		assign drive_d[g] = drive_permit ? i_phase_cmd[g] : spr_pkg::DRIVE_OFF[g]; // R2 R6
	end

	// Fault latch; only a reset clears it, and the clear beats a fault in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			fault_q <= spr_pkg::SPR_FAULT_NONE;
		end else if (soft_rst) begin
			fault_q <= spr_pkg::SPR_FAULT_NONE; // R7 R17
		end else begin
			fault_q <= fault_d; // R6
		end
	end

	// Flag follows the next latch value, so flag and type move on one edge
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_oe_q <= 1'b0;
		end else if (soft_rst) begin
			flag_oe_q <= 1'b0; // R17
		end else begin
			flag_oe_q <= fault_next_any; // R4
		end
	end

	// Blanking counter, held while the internal clock is frozen
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			blank_cnt_q <= spr_pkg::BLANK_ZERO;
		end else if (soft_rst) begin
			blank_cnt_q <= spr_pkg::BLANK_ZERO; // R1
		end else begin
			blank_cnt_q <= blank_cnt_d; // R14
		end
	end

	// Last PWM off level, to find where each off part ends
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pwm_off_q <= 1'b0;
		end else if (soft_rst) begin
			pwm_off_q <= 1'b0;
		end else begin
			pwm_off_q <= ce ? i_pwm_off : pwm_off_q; // R3
		end
	end

	// Flyback seen so far in the current off part
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			flyback_hit_q <= 1'b0;
		end else if (soft_rst) begin
			flyback_hit_q <= 1'b0;
		end else begin
			flyback_hit_q <= flyback_hit_d; // R12
		end
	end

	// Registered drive, so the pins never glitch on decode
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			drive_q <= spr_pkg::DRIVE_OFF;
		end else begin
			drive_q <= drive_d; // R2 R6
		end
	end

	// Blanking indicator tracks the counter's next value, so it lines up with the count
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			blank_q <= 1'b0;
		end else begin
			blank_q <= (blank_cnt_d != spr_pkg::BLANK_ZERO) && !soft_rst; // R14
		end
	end

	assign o_drive = drive_q;
	assign o_sense_blank = blank_q;
	// Open drain: only ever drives low
	assign o_any_fault_flag_low_o = 1'b0;
	assign o_any_fault_flag_low_oe = flag_oe_q; // R4
	assign o_fault_type_level = fault_q; // R5

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	localparam int BLANK_CHK = spr_pkg::BLANK_CYCLES;

	drive_disabled_a: assert property (!en_s |=> o_drive == spr_pkg::DRIVE_OFF) // R2
		else $error("drive not off while disabled");

	fault_drive_off_a: assert property (!no_fault |=> o_drive == spr_pkg::DRIVE_OFF) // R6
		else $error("drive active with a latched fault");

	fault_hold_a: assert property (!no_fault && !soft_rst |=> fault_q == $past(fault_q)) // R6 R7
		else $error("latched fault changed without reset");

	reset_clear_a: assert property (soft_rst |=> no_fault && !o_any_fault_flag_low_oe) // R1 R7 R17
		else $error("external reset did not clear the fault");

	flag_match_a: assert property (o_any_fault_flag_low_oe == (o_fault_type_level != spr_pkg::SPR_FAULT_NONE)) // R4 R17
		else $error("fault flag and fault type disagree");

	frozen_state_a: assert property (!en_s && !soft_rst |=> $stable(fault_q) && $stable(blank_cnt_q)) // R3
		else $error("state moved while disabled");

	blank_load_a: assert property (blank_start |=> blank_cnt_q == BLANK_CHK[spr_pkg::BLANK_W-1:0]) // R14
		else $error("blanking window not loaded at period start");

	blank_range_a: assert property (blank_cnt_q <= BLANK_CHK[spr_pkg::BLANK_W-1:0]) // R14
		else $error("blanking counter out of range");

	oc_after_blank_a: assert property (
		$rose(fault_q == spr_pkg::SPR_FAULT_OVER_CURRENT) |->
		$past(!blank_busy && i_chop_active && en_s)) // R15 R16
		else $error("overcurrent taken inside blanking");

	open_cause_a: assert property (
		$rose(fault_q == spr_pkg::SPR_FAULT_OPEN) |-> $past(off_end && !flyback_hit_q)) // R12
		else $error("open fault without a flyback-free off part");

	heat_cause_a: assert property (
		$rose(fault_q == spr_pkg::SPR_FAULT_OVER_HEAT) |-> $past(over_heat_s && en_s)) // R4
		else $error("overheat fault without cause");

	// Drive follows the command only while every permit holds
	drive_follow_a: assert property (drive_permit |=> o_drive == $past(i_phase_cmd)) // R2
		else $error("drive did not follow the phase command");

	reset_drive_a: assert property (soft_rst |=> o_drive == spr_pkg::DRIVE_OFF) // R1 R2
		else $error("drive not off during external reset");

	frozen_track_a: assert property (!en_s && !soft_rst |=> $stable(pwm_off_q) && $stable(flyback_hit_q)) // R3
		else $error("open-detect state moved while disabled");

	// Fault entry: priority order, and the flag raised on the same edge as the type
	flag_set_a: assert property (
		(heat_event || oc_event || open_event) && !soft_rst |=> o_any_fault_flag_low_oe) // R4 R6
		else $error("fault event did not pull the flag");

	flag_hold_a: assert property (!no_fault && !soft_rst |=> o_any_fault_flag_low_oe) // R4 R6
		else $error("fault flag released without reset");

	heat_type_a: assert property (heat_event && no_fault && !soft_rst |=>
		o_fault_type_level == spr_pkg::SPR_FAULT_OVER_HEAT) // R5
		else $error("overheat not reported as overheat");

	oc_type_a: assert property (oc_event && !heat_event && no_fault && !soft_rst |=>
		o_fault_type_level == spr_pkg::SPR_FAULT_OVER_CURRENT) // R5 R16
		else $error("overcurrent not reported as overcurrent");

	open_type_a: assert property (open_event && !heat_event && !oc_event && no_fault && !soft_rst |=>
		o_fault_type_level == spr_pkg::SPR_FAULT_OPEN) // R5 R12
		else $error("open terminal not reported as open");

	healthy_off_a: assert property (off_end && (flyback_hit_q || flyback_s) && no_fault &&
		!heat_event && !oc_event && !soft_rst |=> no_fault) // R12
		else $error("open fault despite flyback current");

	// Blanking: steady count-down, no window outside chopping, no overcurrent inside
	blank_count_a: assert property (ce && blank_busy && !blank_start |=>
		blank_cnt_q == $past(blank_cnt_q) - spr_pkg::BLANK_STEP) // R14
		else $error("blanking counter skipped a step");

	start_ignored_a: assert property (i_pwm_period_start && !i_chop_active && !blank_busy |=>
		!blank_busy) // R15
		else $error("blanking started outside chopping");

	blank_quiet_a: assert property (!i_chop_active && !blank_busy |=> !o_sense_blank) // R15
		else $error("blanking shown outside chopping");

	oc_blocked_a: assert property (blank_busy && no_fault |=> fault_q != spr_pkg::SPR_FAULT_OVER_CURRENT) // R16
		else $error("overcurrent taken during blanking");

	// Cover points for the main scenarios
	open_seen_c: cover property ($rose(fault_q == spr_pkg::SPR_FAULT_OPEN));
	oc_seen_c: cover property ($rose(fault_q == spr_pkg::SPR_FAULT_OVER_CURRENT));
	heat_seen_c: cover property ($rose(fault_q == spr_pkg::SPR_FAULT_OVER_HEAT));
	fault_cleared_c: cover property (!no_fault ##1 soft_rst ##1 no_fault);
	drive_back_c: cover property (!no_fault ##1 soft_rst ##1 no_fault ##[1:20] o_drive != spr_pkg::DRIVE_OFF);

endmodule // spr_protect

// ===== src/spr_pkg.sv
package spr_pkg;

	// Base clock rate of the protection logic
	localparam int CLK_FREQ_MHZ = 200;

	// Current-sense blanking window at the start of each PWM period
	localparam int BLANK_TIME_NS = 5500;
	// Least time, so rounded up to whole cycles
	localparam int BLANK_CYCLES = (BLANK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int BLANK_W = $clog2(BLANK_CYCLES + 1);
	localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_CYCLES[BLANK_W-1:0];
	localparam logic [BLANK_W-1:0] BLANK_ZERO = '0;
	localparam logic [BLANK_W-1:0] BLANK_STEP = {{(BLANK_W-1){1'b0}}, 1'b1};

	// Four excitation drive outputs, one per phase
	localparam int DRIVE_W = 4;
	localparam logic [DRIVE_W-1:0] DRIVE_OFF = '0;

	// Pin inputs passed through the synchroniser, with their bit positions
	localparam int SYNC_W = 5;
	localparam int SYNC_ENABLE = 0;
	localparam int SYNC_RESET_LOW = 1;
	localparam int SYNC_OVER_CURRENT = 2;
	localparam int SYNC_OVER_HEAT = 3;
	localparam int SYNC_FLYBACK = 4;
	// Idle levels: disabled, reset released, no fault conditions
	localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 5'h02;

	// Fault-type output code, one per analog level of the fault-type pin
	typedef enum logic [1:0] {
		SPR_FAULT_NONE = 2'h0,
		SPR_FAULT_OPEN = 2'h1,
		SPR_FAULT_OVER_CURRENT = 2'h2,
		SPR_FAULT_OVER_HEAT = 2'h3
	} spr_fault_t;

endpackage

// ===== src/spr_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for asynchronous pin levels
module spr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage to contain metastability
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule // spr_sync

// ===== tb/spr_host.sv
`timescale 1ns/1ps

// Host controller: enable level and system reset pulses, changed on the falling edge
module spr_host #(
	parameter int HOLD = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_en_req,
	input wire logic i_clear_req,
	output logic o_enable,
	output logic o_system_reset_low
);
	logic en_q = 1'b0;
	int low_cnt = 0;
	// Enable stays low through power-on reset, so no current flows on weak gate drive
	always @(negedge i_clk_sys) begin
		en_q <= i_nrst && i_en_req;
	end
	// High-low-high pulse, held low long enough for the pin synchroniser
	always @(negedge i_clk_sys) begin
		if (i_clear_req && low_cnt == 0) low_cnt <= HOLD;
		else if (low_cnt > 0) low_cnt <= low_cnt - 1;
	end
	assign o_enable = en_q;
	assign o_system_reset_low = (low_cnt == 0);
endmodule // spr_host

// ===== tb/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic en_req = 1'b0;
	logic clear_req = 1'b0;
	logic [3:0] phase = 4'h0;
	logic chop = 1'b0;
	logic start = 1'b0;
	logic pwm_off = 1'b0;
	logic oc = 1'b0;
	logic heat = 1'b0;
	logic fly = 1'b0;
	logic enable, sys_rst_low, blank, flag_o, flag_oe;
	logic [3:0] drive;
	logic [3:0] p;
	logic [1:0] ftype;
	logic [3:0] exp_q[$];
	int bad_count = 0;
	int check_count = 0;
	int n;
	// Host waits at 5 ns a cycle: 10 us after a reset release, 30 us after enable rises
	localparam int RESET_WAIT = 2000;
	localparam int ENABLE_WAIT = 6000;
	// Free-running 200 MHz system clock
	always #2.5 clk = ~clk;
	spr_host i_spr_host (.i_clk_sys(clk), .i_nrst(nrst), .i_en_req(en_req), .i_clear_req(clear_req),
		.o_enable(enable), .o_system_reset_low(sys_rst_low));
	spr_protect i_spr_protect (.i_clk_sys(clk), .i_nrst(nrst), .i_enable(enable),
		.i_system_reset_low(sys_rst_low), .i_phase_cmd(phase), .i_chop_active(chop),
		.i_pwm_period_start(start), .i_pwm_off(pwm_off), .i_over_current_cmp(oc), .i_over_heat(heat),
		.i_flyback_seen(fly), .o_drive(drive), .o_sense_blank(blank), .o_any_fault_flag_low_o(flag_o),
		.o_any_fault_flag_low_oe(flag_oe), .o_fault_type_level(ftype));
	// Shared helpers; values are read on the falling edge, where they are settled
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic report(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic check_drive(input logic [3:0] exp);
		report({8'h00, drive}, {8'h00, exp});
	endtask
	// Open-drain data must stay 0; the pin is pulled low exactly while a fault is held
	task automatic check_fault(input logic [1:0] exp);
		report({7'h00, flag_o, flag_oe, 1'b0, ftype}, {7'h00, 1'b0, exp != 2'h0, 1'b0, exp});
	endtask
	task automatic check_len(input int got);
		report(12'(got), 12'(spr_pkg::BLANK_CYCLES));
	endtask
	task automatic check_blank(input logic exp);
		report({11'h000, blank}, {11'h000, exp});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog: the tests take about 15k cycles, so 40k cycles can only mean a hang
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		n = $urandom(38043);
		cyc(10);
		nrst <= 1'b1;
		en_req <= 1'b1;
		cyc(RESET_WAIT);
		repeat (16) begin
			p = 4'($urandom);
			phase <= p;
			exp_q.push_back(p);
			cyc(1);
			check_drive(exp_q.pop_front());
		end
		// Slow-down: each step waits one cycle longer than the one before
		for (int k = 1; k <= 4; k++) begin
			p = 4'($urandom);
			phase <= p;
			exp_q.push_back(p);
			cyc(k);
			check_drive(exp_q.pop_front());
		end
		en_req <= 1'b0;
		phase <= 4'hF;
		cyc(6);
		check_drive(4'h0);
		heat <= 1'b1;
		cyc(4);
		heat <= 1'b0;
		cyc(4);
		check_fault(2'h0);
		en_req <= 1'b1;
		cyc(6);
		check_drive(4'hF);
		$display("test drive and enable done");
		cyc(ENABLE_WAIT);
		// Overcurrent inside the blanking window must be ignored
		chop <= 1'b1;
		start <= 1'b1;
		cyc(1);
		start <= 1'b0;
		oc <= 1'b1;
		n = 0;
		for (int i = 0; i < 1200; i++) begin
			if (blank === 1'b1) n++;
			if (i == 500) oc <= 1'b0;
			cyc(1);
		end
		check_len(n);
		check_fault(2'h0);
		chop <= 1'b0;
		start <= 1'b1;
		cyc(1);
		start <= 1'b0;
		cyc(1);
		check_blank(1'b0);
		chop <= 1'b1;
		oc <= 1'b1;
		cyc(5);
		check_fault(2'h2);
		check_drive(4'h0);
		oc <= 1'b0;
		chop <= 1'b0;
		en_req <= 1'b0;
		cyc(6);
		en_req <= 1'b1;
		cyc(6);
		check_fault(2'h2);
		$display("test blanking and overcurrent done");
		clear_req <= 1'b1;
		cyc(1);
		clear_req <= 1'b0;
		for (int i = 0; i < 20 && flag_oe !== 1'b0; i++) cyc(1);
		check_fault(2'h0);
		cyc(8);
		check_drive(4'hF);
		cyc(ENABLE_WAIT);
		chop <= 1'b1;
		// Off part with flyback is healthy; without it the terminal is open
		pwm_off <= 1'b1;
		fly <= 1'b1;
		cyc(10);
		pwm_off <= 1'b0;
		fly <= 1'b0;
		cyc(5);
		check_fault(2'h0);
		pwm_off <= 1'b1;
		cyc(10);
		pwm_off <= 1'b0;
		cyc(5);
		check_fault(2'h1);
		check_drive(4'h0);
		$display("test open terminal done");
		chop <= 1'b0;
		nrst <= 1'b0;
		cyc(2);
		check_fault(2'h0);
		nrst <= 1'b1;
		cyc(8);
		heat <= 1'b1;
		cyc(5);
		check_fault(2'h3);
		heat <= 1'b0;
		clear_req <= 1'b1;
		cyc(1);
		clear_req <= 1'b0;
		cyc(10);
		check_fault(2'h0);
		$display("test overheat and resets done");
		complete_run();
	end
endmodule // testbench
